// *** hw/pmx_consts.svh ***
// register offsets, field positions, reset values and sizes for the port override block
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH
`define PMX_OFS_PORT_E   8'h00
`define PMX_OFS_DIR_E    8'h04
`define PMX_OFS_PORT_F   8'h08
`define PMX_OFS_DIR_F    8'h0c
`define PMX_OFS_PORT_G   8'h10
`define PMX_OFS_DIR_G    8'h14
`define PMX_OFS_CTRL     8'h18
`define PMX_OFS_PINS     8'h1c
`define PMX_OFS_TAP      8'h20
`define PMX_CTRL_PUD     0
`define PMX_CTRL_COMPAT  1
`define PMX_REG_RST      8'h00
`define PMX_F_PU_RST     8'hb0
`define PMX_IR_W         4
`define PMX_IR_CAPTURE   4'h1
`define PMX_G_W          5
`endif

// *** hw/pmx_pkg.sv ***
// types shared by the port override block
package pmx_pkg;
    typedef struct packed {
        logic       usart0_transmit_enable;
        logic       usart0_receive_enable;
        logic       usart0_sync_mode_select;
        logic       usart0_ext_clock;
        logic       usart0_transmit_line;
        logic [2:0] timer3_compare_enable;  // c, b, a
        logic       timer3_compare_out_c;
        logic       timer3_compare_out_b;
        logic       timer3_compare_out_a;
        logic [3:0] ext_irq_enable;         // seven, six, five, four
        logic       test_port_enable;
        logic       timer0_async_clock_select;
        logic       sleep_digin_off;
    } pmx_periph_t;
    typedef struct packed {
        logic [7:0] e;
        logic [7:0] f;
        logic [4:0] g;
    } pmx_pins_t;
    typedef struct packed {
        logic       usart0_receive_line;
        logic       usart0_ext_clock_in;
        logic [3:0] ext_irq_in;             // seven, six, five, four
        logic       timer3_capture_input;
        logic       timer3_count_input;
        logic       comparator_negative_input;
        logic       comparator_positive_input;
        logic [7:0] analog_pin_tap;
        logic       timer_osc_pin_one;
        logic       timer_osc_pin_two;
    } pmx_taps_t;
    typedef enum logic [3:0] {
        PMX_TLR, PMX_RTI, PMX_SEL_DR, PMX_CAP_DR, PMX_SH_DR, PMX_EX1_DR, PMX_PA_DR,
        PMX_EX2_DR, PMX_UPD_DR, PMX_SEL_IR, PMX_CAP_IR, PMX_SH_IR, PMX_EX1_IR,
        PMX_PA_IR, PMX_EX2_IR, PMX_UPD_IR
    } pmx_tap_state_t;
endpackage : pmx_pkg

// *** hw/pmx_override.sv ***
// port e/f/g alternate function override with apb port registers and test port controller
//
// Functional notes
// - receiver enabled forces port e bit 0 to input, level goes to receiver
// - forced receive pin gets pull-up when its output bit is one, pull-ups allowed
// - irq enables force digital input on e7..e4; e5,e4 take timer3 compares c,b
// - transmit enable on e1: pull-up off, output direction, value from transmitter
// - legacy mode makes every port f pin input only, except f6 in shift states while the test port is enabled
// - test port enabled keeps tdi, tms, tck pull-ups active, even in reset
// - f6 drives test output only in shift states, else tri-state without pull-up
// - test port runs on tck; tms steps the controller, tdi feeds scan registers
// - port f bits 3..0 have no digital override, only feed analog channels
// - legacy mode leaves port g to alternate functions, no general digital use
// - timer0 async select frees g4,g3 from the port for the crystal oscillator
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "pmx_consts.svh"

module pmx_override
    import pmx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire pmx_periph_t periph,
    input  wire pmx_pins_t   pins_in,
    output pmx_pins_t        pins_out,
    output pmx_pins_t        pins_oe,
    output pmx_pins_t        pins_pu,
    output pmx_taps_t        taps
);
    // ==========================================================
    // override selection
    function automatic logic ovr(input logic en, input logic val, input logic norm);
        return en ? val : norm;
    endfunction : ovr

    function automatic logic mapped(input logic [7:0] a);
        return a <= `PMX_OFS_TAP && a[1:0] == 2'b00;
    endfunction : mapped

    // ==========================================================
    // state
    logic [7:0]     port_e, port_f, dir_e, dir_f, ctrl;
    logic [4:0]     port_g, dir_g;
    logic [7:0]     next_port_e, next_port_f, next_dir_e, next_dir_f, next_ctrl;
    logic [4:0]     next_port_g, next_dir_g;
    logic [31:0]    next_prdata;
    logic           next_pready, next_pslverr;
    pmx_tap_state_t tap, next_tap;
    logic [3:0]     ir_sr, ir, next_ir_sr, next_ir;
    logic           bypass, tdo_q, tck_q, next_bypass, next_tdo_q;
    pmx_pins_t      next_out, next_oe, next_pu, de;
    pmx_taps_t      next_taps;
    logic           global_pullup_disable, compat, jtag, as0, shifting, tck_rise, tck_fall, wr;

    assign global_pullup_disable      = ctrl[`PMX_CTRL_PUD];
    assign compat   = ctrl[`PMX_CTRL_COMPAT];
    assign jtag     = periph.test_port_enable;
    assign as0      = periph.timer0_async_clock_select;
    assign shifting = tap == PMX_SH_IR || tap == PMX_SH_DR;
    assign tck_rise = pins_in.f[4] & ~tck_q;
    assign tck_fall = ~pins_in.f[4] & tck_q;
    assign wr       = psel & penable & pready & pwrite;

    // ==========================================================
    // apb slave: answer one cycle into the access phase
    always_comb
    begin
        next_port_e  = port_e;
        next_port_f  = port_f;
        next_port_g  = port_g;
        next_dir_e   = dir_e;
        next_dir_f   = dir_f;
        next_dir_g   = dir_g;
        next_ctrl    = ctrl;
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~mapped(paddr);
        next_prdata  = 32'h0;
        if (wr)
        begin
            case (paddr)
                `PMX_OFS_PORT_E: next_port_e = pwdata[7:0];
                `PMX_OFS_DIR_E:  next_dir_e  = pwdata[7:0];
                `PMX_OFS_PORT_F: next_port_f = pwdata[7:0];
                `PMX_OFS_DIR_F:  next_dir_f  = pwdata[7:0];
                `PMX_OFS_PORT_G: next_port_g = pwdata[4:0];
                `PMX_OFS_DIR_G:  next_dir_g  = pwdata[4:0];
                `PMX_OFS_CTRL:   next_ctrl   = {6'h00, pwdata[1:0]};
                default:         next_ctrl   = ctrl;
            endcase
        end
        if (psel & penable & ~pready & ~pwrite)
        begin
            case (paddr)
                `PMX_OFS_PORT_E: next_prdata = {24'h0, port_e};
                `PMX_OFS_DIR_E:  next_prdata = {24'h0, dir_e};
                `PMX_OFS_PORT_F: next_prdata = {24'h0, port_f};
                `PMX_OFS_DIR_F:  next_prdata = {24'h0, dir_f};
                `PMX_OFS_PORT_G: next_prdata = {27'h0, port_g};
                `PMX_OFS_DIR_G:  next_prdata = {27'h0, dir_g};
                `PMX_OFS_CTRL:   next_prdata = {24'h0, ctrl};
                `PMX_OFS_PINS:   next_prdata = {11'h0, pins_in};
                `PMX_OFS_TAP:    next_prdata = {24'h0, ir, tap};
                default:         next_prdata = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // test port controller, stepped by tck edges seen on f4
    always_comb
    begin
        next_tap    = tap;
        next_ir_sr  = ir_sr;
        next_ir     = ir;
        next_bypass = bypass;
        next_tdo_q  = tdo_q;
        if (!jtag)
            next_tap = PMX_TLR;
        else if (tck_rise)
        begin
            case (tap)
                PMX_TLR:    next_tap = pins_in.f[5] ? PMX_TLR : PMX_RTI;
                PMX_RTI:    next_tap = pins_in.f[5] ? PMX_SEL_DR : PMX_RTI;
                PMX_SEL_DR: next_tap = pins_in.f[5] ? PMX_SEL_IR : PMX_CAP_DR;
                PMX_CAP_DR: next_tap = pins_in.f[5] ? PMX_EX1_DR : PMX_SH_DR;
                PMX_SH_DR:  next_tap = pins_in.f[5] ? PMX_EX1_DR : PMX_SH_DR;
                PMX_EX1_DR: next_tap = pins_in.f[5] ? PMX_UPD_DR : PMX_PA_DR;
                PMX_PA_DR:  next_tap = pins_in.f[5] ? PMX_EX2_DR : PMX_PA_DR;
                PMX_EX2_DR: next_tap = pins_in.f[5] ? PMX_UPD_DR : PMX_SH_DR;
                PMX_UPD_DR: next_tap = pins_in.f[5] ? PMX_SEL_DR : PMX_RTI;
                PMX_SEL_IR: next_tap = pins_in.f[5] ? PMX_TLR : PMX_CAP_IR;
                PMX_CAP_IR: next_tap = pins_in.f[5] ? PMX_EX1_IR : PMX_SH_IR;
                PMX_SH_IR:  next_tap = pins_in.f[5] ? PMX_EX1_IR : PMX_SH_IR;
                PMX_EX1_IR: next_tap = pins_in.f[5] ? PMX_UPD_IR : PMX_PA_IR;
                PMX_PA_IR:  next_tap = pins_in.f[5] ? PMX_EX2_IR : PMX_PA_IR;
                PMX_EX2_IR: next_tap = pins_in.f[5] ? PMX_UPD_IR : PMX_SH_IR;
                PMX_UPD_IR: next_tap = pins_in.f[5] ? PMX_SEL_DR : PMX_RTI;
                default:    next_tap = PMX_TLR;
            endcase
            // tdi shifts into the selected scan register
            case (tap)
                PMX_CAP_IR: next_ir_sr  = `PMX_IR_CAPTURE;
                PMX_SH_IR:  next_ir_sr  = {pins_in.f[7], ir_sr[3:1]};
                PMX_UPD_IR: next_ir     = ir_sr;
                PMX_CAP_DR: next_bypass = 1'b0;
                PMX_SH_DR:  next_bypass = pins_in.f[7];
                default:    next_bypass = bypass;
            endcase
        end
        // output changes on the falling tck so the far end samples it stable
        if (jtag && tck_fall)
            next_tdo_q = (tap == PMX_SH_IR) ? ir_sr[0] : bypass;
    end

    // ==========================================================
    // pin override network
    always_comb
    begin
        next_out.e = port_e;
        next_oe.e  = dir_e;
        next_pu.e  = port_e & ~dir_e & {8{~global_pullup_disable}};
        de.e       = {8{~periph.sleep_digin_off}};
        next_out.f = port_f;
        next_oe.f  = compat ? 8'h00 : dir_f;
        next_pu.f  = port_f & ~next_oe.f & {8{~global_pullup_disable}};
        de.f       = {8{~periph.sleep_digin_off}};
        // legacy mode: no general digital use of port g
        next_out.g = compat ? 5'h00 : port_g;
        next_oe.g  = compat ? 5'h00 : dir_g;
        next_pu.g  = port_g & ~next_oe.g & {5{~global_pullup_disable & ~compat}};
        de.g       = {5{~periph.sleep_digin_off & ~compat}};

        next_oe.e[0] = ovr(periph.usart0_receive_enable, 1'b0, next_oe.e[0]);
        next_pu.e[0] = ovr(periph.usart0_receive_enable, port_e[0] & ~global_pullup_disable,
                           next_pu.e[0]);
        next_pu.e[1]  = ovr(periph.usart0_transmit_enable, 1'b0, next_pu.e[1]);
        next_oe.e[1]  = ovr(periph.usart0_transmit_enable, 1'b1, next_oe.e[1]);
        next_out.e[1] = ovr(periph.usart0_transmit_enable, periph.usart0_transmit_line,
                            next_out.e[1]);
        next_out.e[2] = ovr(periph.usart0_sync_mode_select, periph.usart0_ext_clock,
                            next_out.e[2]);
        next_out.e[3] = ovr(periph.timer3_compare_enable[0], periph.timer3_compare_out_a,
                            next_out.e[3]);
        next_out.e[4] = ovr(periph.timer3_compare_enable[1], periph.timer3_compare_out_b,
                            next_out.e[4]);
        next_out.e[5] = ovr(periph.timer3_compare_enable[2], periph.timer3_compare_out_c,
                            next_out.e[5]);
        for (int i = 0; i < 4; i++)
            de.e[i+4] = ovr(periph.ext_irq_enable[i], 1'b1, de.e[i+4]);

        for (int i = 4; i < 8; i++)
        begin
            // tdi, tms, tck: inputs with pull-up, digital buffer off
            next_pu.f[i] = ovr(jtag, i != 6, next_pu.f[i]);
            next_oe.f[i] = ovr(jtag, 1'b0, next_oe.f[i]);
            de.f[i]      = ovr(jtag, 1'b0, de.f[i]);
        end
        next_oe.f[6]  = ovr(jtag, shifting, next_oe.f[6]);
        next_out.f[6] = ovr(jtag, tdo_q, next_out.f[6]);

        for (int i = 3; i < 5; i++)
        begin
            next_pu.g[i] = ovr(as0, 1'b0, next_pu.g[i]);
            next_oe.g[i] = ovr(as0, 1'b0, next_oe.g[i]);
            de.g[i]      = ovr(as0, 1'b0, de.g[i]);
        end
        next_out.g[4:3] = as0 ? 2'b00 : next_out.g[4:3];

        next_taps.usart0_receive_line       = pins_in.e[0] & de.e[0];
        next_taps.usart0_ext_clock_in       = pins_in.e[2] & de.e[2];
        next_taps.ext_irq_in                = pins_in.e[7:4] & de.e[7:4];
        next_taps.timer3_capture_input      = pins_in.e[7] & de.e[7];
        next_taps.timer3_count_input        = pins_in.e[6] & de.e[6];
        next_taps.comparator_negative_input = pins_in.e[3];
        next_taps.comparator_positive_input = pins_in.e[2];
        next_taps.analog_pin_tap            = pins_in.f;
        next_taps.timer_osc_pin_one         = pins_in.g[4];
        next_taps.timer_osc_pin_two         = pins_in.g[3];
    end

    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_e   <= `PMX_REG_RST;
            port_f   <= `PMX_REG_RST;
            port_g   <= 5'h00;
            dir_e    <= `PMX_REG_RST;
            dir_f    <= `PMX_REG_RST;
            dir_g    <= 5'h00;
            ctrl     <= `PMX_REG_RST;
            prdata   <= 32'h0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            tap      <= PMX_TLR;
            ir_sr    <= 4'h0;
            ir       <= 4'h0;
            bypass   <= 1'b0;
            tdo_q    <= 1'b0;
            tck_q    <= 1'b1;  // tck idles high on its pull-up: no false rise after reset
            pins_out <= '0;
            pins_oe  <= '0;
            // test pull-ups held through reset; assumes the enable fuse is set
            pins_pu  <= {8'h00, `PMX_F_PU_RST, 5'h00};
            taps     <= '0;
        end
        else
        begin
            port_e   <= next_port_e;
            port_f   <= next_port_f;
            port_g   <= next_port_g;
            dir_e    <= next_dir_e;
            dir_f    <= next_dir_f;
            dir_g    <= next_dir_g;
            ctrl     <= next_ctrl;
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
            tap      <= next_tap;
            ir_sr    <= next_ir_sr;
            ir       <= next_ir;
            bypass   <= next_bypass;
            tdo_q    <= next_tdo_q;
            tck_q    <= pins_in.f[4];
            pins_out <= next_out;
            pins_oe  <= next_oe;
            pins_pu  <= next_pu;
            taps     <= next_taps;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence tck_up_tms_high;
        jtag && tck_rise && pins_in.f[5];
    endsequence
    sequence apb_access_wait;
        psel && penable && !pready;
    endsequence

    AST_RX_INPUT: assert property (periph.usart0_receive_enable |=> !pins_oe.e[0])
        else $error("receive pin not forced to input");
    AST_RX_PULLUP: assert property (periph.usart0_receive_enable |=>
        pins_pu.e[0] == ($past(port_e[0]) && !$past(global_pullup_disable)))
        else $error("receive pin pull-up wrong");
    AST_IRQ_DIGIN: assert property (periph.ext_irq_enable[3] |=>
        taps.ext_irq_in[3] == $past(pins_in.e[7]))
        else $error("irq input not forced on");
    AST_TX_DRIVE: assert property (periph.usart0_transmit_enable |=>
        pins_oe.e[1] && !pins_pu.e[1] && pins_out.e[1] == $past(periph.usart0_transmit_line))
        else $error("transmit pin override wrong");
    AST_XCK_OUT: assert property (periph.usart0_sync_mode_select |=>
        pins_out.e[2] == $past(periph.usart0_ext_clock) && pins_oe.e[2] == $past(dir_e[2]))
        else $error("usart clock pin wrong");
    AST_F_LEGACY: assert property (compat && !jtag |=> pins_oe.f == 8'h00)
        else $error("port f drives in legacy mode");
    AST_TEST_PINS: assert property (jtag |=> pins_pu.f[7] && pins_pu.f[5] && pins_pu.f[4]
        && !pins_oe.f[7] && !pins_oe.f[5] && !pins_oe.f[4])
        else $error("test input pins not held as pulled-up inputs");
    AST_TDO_TRI: assert property (jtag && !shifting |=> !pins_oe.f[6] && !pins_pu.f[6])
        else $error("test output driven outside shift");
    AST_TAP_STEP: assert property (tap == PMX_SH_DR ##0 tck_up_tms_high |=> tap == PMX_EX1_DR)
        else $error("controller did not leave shift");
    AST_F_LOW: assert property (!compat |=> pins_oe.f[3:0] == $past(dir_f[3:0]))
        else $error("low port f bits overridden");
    AST_G_LEGACY: assert property (compat |=> pins_oe.g == 5'h00)
        else $error("port g general use in legacy mode");
    AST_OSC_PINS: assert property (as0 |=> !pins_oe.g[4] && !pins_oe.g[3] && !pins_pu.g[3])
        else $error("oscillator pins still on port");
    AST_NO_OVR: assert property (!periph.usart0_transmit_enable |=>
        pins_out.e[1] == $past(port_e[1]))
        else $error("override without enable");
    AST_TIMER3_COMPARE_OUT_A: assert property (periph.timer3_compare_enable[0] |=>
        pins_out.e[3] == $past(periph.timer3_compare_out_a))
        else $error("compare a not on e3");
    AST_APB_ANSWER: assert property (apb_access_wait |=> pready ##1 !pready)
        else $error("apb answer late");
endmodule : pmx_override

// *** verif/pmx_pad_model.sv ***
// pad model: resolves each pin from the block, an outside driver and the pull-up
`timescale 1ns/100ps

module pmx_pad_model
    import pmx_pkg::*;
(
    input  wire logic      pclk,
    input  wire pmx_pins_t pins_out,
    input  wire pmx_pins_t pins_oe,
    input  wire pmx_pins_t pins_pu,
    input  wire pmx_pins_t ext_val,
    input  wire pmx_pins_t ext_en,
    output pmx_pins_t      pins_in
);
    // a floating pin wanders every cycle so a stale level never reads as valid
    logic [20:0] float_pat = 21'h0a5a5;
    always @(posedge pclk)
    begin
        float_pat <= ~float_pat;
    end

    // the block wins over the outside driver; bench never drives a pin the block drives
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_en & ext_val)
                   | (~pins_oe & ~ext_en & pins_pu)
                   | (~pins_oe & ~ext_en & ~pins_pu & float_pat);
endmodule : pmx_pad_model

// *** verif/port_efg_alt_function_override_test.sv ***
// self-checking bench for the port e/f/g override block
`timescale 1ns/100ps
`include "pmx_consts.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end

module port_efg_alt_function_override_test
    import pmx_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    pmx_periph_t periph;
    pmx_pins_t   pins_in, pins_out, pins_oe, pins_pu, ext_val, ext_en;
    pmx_taps_t   taps;
    int          mismatches, compares;

    pmx_override uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph(periph), .pins_in(pins_in), .pins_out(pins_out),
        .pins_oe(pins_oe), .pins_pu(pins_pu), .taps(taps));

    pmx_pad_model pads (.pclk(pclk), .pins_out(pins_out), .pins_oe(pins_oe),
        .pins_pu(pins_pu), .ext_val(ext_val), .ext_en(ext_en), .pins_in(pins_in));

    function automatic pmx_pins_t mk(input logic [7:0] e, input logic [7:0] f,
                                     input logic [4:0] g);
        mk = {e, f, g};
    endfunction : mk

    task end_sim;
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // apb master; waits on pready with no assumed latency
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
            if (n > 40)
            begin
                mismatches++;
                end_sim;
            end
        end
        while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, exp)
        `CHK(rerr, eerr)
    endtask : rd

    // outputs are registered and pad feedback adds one more stage
    task settle;
        repeat (4) @(posedge pclk);
    endtask : settle

    // each tck level held two pclk so the edge detector sees it
    task tck_step(input logic tms);
        ext_val.f[5] <= tms;
        repeat (2) @(posedge pclk);
        ext_val.f[4] <= 1'b1;
        repeat (2) @(posedge pclk);
        ext_val.f[4] <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : tck_step

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        #2000000;
        mismatches++;
        end_sim;
    end

    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; periph = '0; ext_val = '0; ext_en = '0;
        mismatches = 0; compares = 0;
        repeat (6) @(posedge pclk);
        `CHK(pins_pu, mk(8'h00, 8'hb0, 5'h00))
        `CHK(pins_oe, mk(8'h00, 8'h00, 5'h00))
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PMX_OFS_PORT_E, 32'h0, 1'b0);
        wr(`PMX_OFS_PORT_E, 32'h03);
        rd(`PMX_OFS_PORT_E, 32'h03, 1'b0);
        rd(8'h24, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        wr(`PMX_OFS_DIR_E, 32'h3d);
        rd(`PMX_OFS_DIR_E, 32'h3d, 1'b0);
        settle;
        `CHK(pins_pu.e[1], 1'b1)
        `CHK(pins_oe.e[0], 1'b1)
        periph.usart0_transmit_enable <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            periph.usart0_transmit_line <= i[0];
            settle;
            `CHK(pins_oe.e[1], 1'b1)
            `CHK(pins_pu.e[1], 1'b0)
            `CHK(pins_out.e[1], i[0])
        end
        periph.usart0_receive_enable <= 1'b1;
        ext_en.e[0] <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            ext_val.e[0] <= i[0];
            settle;
            `CHK(pins_oe.e[0], 1'b0)
            `CHK(pins_pu.e[0], 1'b1)
            `CHK(taps.usart0_receive_line, i[0])
        end
        wr(`PMX_OFS_CTRL, 32'h1);
        settle;
        `CHK(pins_pu.e[0], 1'b0)
        wr(`PMX_OFS_CTRL, 32'h0);
        periph.usart0_sync_mode_select <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            periph.usart0_ext_clock <= i[0];
            settle;
            `CHK(pins_out.e[2], i[0])
            `CHK(pins_oe.e[2], 1'b1)
            `CHK(taps.usart0_ext_clock_in, i[0])
            `CHK(taps.comparator_positive_input, i[0])
        end
        periph.timer3_compare_enable <= 3'b111;
        for (int i = 0; i < 2; i++)
        begin
            {periph.timer3_compare_out_c, periph.timer3_compare_out_b,
             periph.timer3_compare_out_a} <= i[0] ? 3'b010 : 3'b101;
            settle;
            `CHK(pins_out.e[5:3], (i[0] ? 3'b010 : 3'b101))
            `CHK(taps.comparator_negative_input, ~i[0])
        end
        periph.timer3_compare_enable <= 3'b000;
        settle;
        `CHK(pins_out.e[5:3], 3'b000)
        periph.sleep_digin_off <= 1'b1;
        ext_en.e[7:6] <= 2'b11;
        ext_val.e[7:6] <= 2'b10;
        periph.ext_irq_enable <= 4'b1100;
        settle;
        `CHK(taps.ext_irq_in, 4'b1000)
        `CHK({taps.timer3_capture_input, taps.timer3_count_input}, 2'b10)
        periph.ext_irq_enable <= 4'b0000;
        settle;
        `CHK(taps.ext_irq_in, 4'b0000)
        `CHK({taps.timer3_capture_input, taps.timer3_count_input}, 2'b00)
        periph.sleep_digin_off <= 1'b0;
        wr(`PMX_OFS_DIR_F, 32'h0f);
        // port f outputs are set once and never toggled afterwards
        wr(`PMX_OFS_PORT_F, 32'h05);
        wr(`PMX_OFS_DIR_G, 32'h0f);
        wr(`PMX_OFS_PORT_G, 32'h1f);
        wr(`PMX_OFS_CTRL, 32'h2);
        settle;
        `CHK(pins_oe.f, 8'h00)
        `CHK(pins_oe.g, 5'h00)
        `CHK(pins_pu.g, 5'h00)
        wr(`PMX_OFS_CTRL, 32'h0);
        settle;
        `CHK(pins_oe.g, 5'h0f)
        `CHK(pins_pu.g, 5'h10)
        periph.timer0_async_clock_select <= 1'b1;
        settle;
        `CHK(pins_oe.g, 5'h07)
        `CHK(pins_pu.g, 5'h00)
        ext_en.g[4:3] <= 2'b11;
        ext_val.g[4:3] <= 2'b10;
        settle;
        `CHK({taps.timer_osc_pin_one, taps.timer_osc_pin_two}, 2'b10)
        ext_en.f <= 8'hb0;
        periph.test_port_enable <= 1'b1;
        settle;
        `CHK(pins_pu.f, 8'hb0)
        `CHK(pins_oe.f, 8'h0f)
        `CHK(pins_out.f[3:0], 4'h5)
        `CHK(taps.analog_pin_tap[3:0], 4'h5)
        tck_step(1'b0);
        tck_step(1'b1);
        tck_step(1'b0);
        tck_step(1'b0);
        `CHK(pins_oe.f[6], 1'b1)
        apb(1'b0, `PMX_OFS_TAP, 32'h0);
        `CHK(rdata[3:0], PMX_SH_DR)
        // a one on tdi goes through the bypass stage and out on the falling tck
        ext_val.f[7] <= 1'b1;
        tck_step(1'b1);
        @(posedge pclk);
        `CHK(pins_oe.f[6], 1'b0)
        `CHK(pins_pu.f[6], 1'b0)
        `CHK(pins_out.f[6], 1'b1)
        end_sim;
    end
endmodule : port_efg_alt_function_override_test
